// ---- rtl/ips_map.svh ----
// Offsets, field widths, reset values and counts of the priority selector.
// Assumes byte addresses on a 32-bit APB with one register per word.
`ifndef IPS_MAP_SVH
`define IPS_MAP_SVH
`define IPS_ADDR_W      12
`define IPS_LVL_W       4
`define IPS_NREQ        128
`define IPS_NNMI        8
`define IPS_ID_W        7
`define IPS_NID_W       3
`define IPS_HOLD_WORDS  16
`define IPS_MASK_RST    4'hF
`define IPS_LVL_RST     4'hF
`define IPS_OFS_MASK    12'h000
`define IPS_OFS_STATUS  12'h004
`define IPS_OFS_NMI_VEC 12'h008
`define IPS_OFS_NHOLD   12'h00C
`define IPS_OFS_NCLR    12'h010
`define IPS_OFS_HCLR    12'h014
`define IPS_OFS_EN      12'h020
`define IPS_OFS_HOLD    12'h040
`define IPS_OFS_LVL     12'h100
`define IPS_OFS_NLVL    12'h300
`endif

// ---- rtl/ips_pkg.sv ----
// Types of the interrupt priority selector: state, register regions, APB.
// Assumes ips_map.svh is on the include path.
`include "ips_map.svh"
package ips_pkg;
   typedef enum logic [1:0] {ST_IDLE, ST_EVAL, ST_OFFER} ips_st_t;
   typedef enum logic [3:0] {
      RG_MASK, RG_STATUS, RG_NMI_VEC, RG_NHOLD, RG_NCLR, RG_HCLR,
      RG_EN, RG_HOLD, RG_LVL, RG_NLVL, RG_NONE
   } ips_rg_t;
   typedef logic [`IPS_LVL_W-1:0] ips_lvl_t;
   typedef struct packed {
      logic                  psel;
      logic                  penable;
      logic                  pwrite;
      logic [`IPS_ADDR_W-1:0] paddr;
      logic [31:0]           pwdata;
      logic [3:0]            pstrb;
   } ips_apb_req_t;
   typedef struct packed {
      ips_st_t                          st;
      ips_lvl_t                         mask;
      ips_lvl_t                         mask_l;
      ips_lvl_t [`IPS_NREQ-1:0]         lvl;
      ips_lvl_t [`IPS_NREQ-1:0]         lvl_l;
      ips_lvl_t [`IPS_NNMI-1:0]         nlvl;
      ips_lvl_t [`IPS_NNMI-1:0]         nlvl_l;
      logic [`IPS_NREQ-1:0]             en;
      logic [`IPS_NREQ-1:0]             hold;
      logic [`IPS_NREQ-1:0]             cand_l;
      logic [`IPS_NNMI-1:0]             nhold;
      logic [`IPS_NNMI-1:0]             ncand_l;
      logic                             sel_nmi;
      logic [`IPS_ID_W-1:0]             sel_id;
      ips_lvl_t                         sel_lvl;
      logic                             vec_valid;
      logic                             nmi_valid;
      logic                             busy;
      logic [31:0]                      prdata;
      logic                             pready;
      logic                             pslverr;
   } ips_state_t;
endpackage

// ---- rtl/ips_selector.sv ----
// Interrupt priority selector with APB registers and vectored handover.
// Assumes request inputs synchronous to pclk and a core that pulses
// vec_ack for one cycle when it fetches the offered vector.
//
// Design decisions made here: the placing of the registers and the APB register port.
`timescale 1ns/1ps
`include "ips_map.svh"
module ips_selector (
   // APB slave
   input  wire logic                 pclk,
   input  wire logic                 presetn,
   input  wire ips_pkg::ips_apb_req_t apb_i,
   output logic [31:0]               prdata,
   output logic                      pready,
   output logic                      pslverr,
   // Interrupt sources
   input  wire logic [`IPS_NREQ-1:0] request_in,
   input  wire logic [`IPS_NNMI-1:0] nonmaskable_in,
   // Vectored handover port to the core
   output logic                      vec_valid,
   output logic [`IPS_ID_W-1:0]      vec_id,
   output logic [`IPS_LVL_W-1:0]     vec_level,
   input  wire logic                 vec_ack,
   // Nonmaskable offer and status
   output logic                      nmi_valid,
   output logic [`IPS_NID_W-1:0]     nmi_id,
   output logic                      busy
);
   ips_pkg::ips_state_t s_r;
   ips_pkg::ips_state_t s_nxt;

   function automatic ips_pkg::ips_rg_t region(
      input logic [`IPS_ADDR_W-1:0] a);
      ips_pkg::ips_rg_t r;
      r = ips_pkg::RG_NONE;
      if (a[1:0] == 2'h0) begin
         if (a == `IPS_OFS_MASK) r = ips_pkg::RG_MASK;
         else if (a == `IPS_OFS_STATUS) r = ips_pkg::RG_STATUS;
         else if (a == `IPS_OFS_NMI_VEC) r = ips_pkg::RG_NMI_VEC;
         else if (a == `IPS_OFS_NHOLD) r = ips_pkg::RG_NHOLD;
         else if (a == `IPS_OFS_NCLR) r = ips_pkg::RG_NCLR;
         else if (a == `IPS_OFS_HCLR) r = ips_pkg::RG_HCLR;
         else if (a >= `IPS_OFS_EN && a < `IPS_OFS_EN + 12'h010)
            r = ips_pkg::RG_EN;
         else if (a >= `IPS_OFS_HOLD && a < `IPS_OFS_HOLD + 12'h040)
            r = ips_pkg::RG_HOLD;
         else if (a >= `IPS_OFS_LVL && a < `IPS_OFS_LVL + 12'h200)
            r = ips_pkg::RG_LVL;
         else if (a >= `IPS_OFS_NLVL && a < `IPS_OFS_NLVL + 12'h020)
            r = ips_pkg::RG_NLVL;
      end
      return r;
   endfunction

   logic                      setup_c;
   logic                      acc_c;
   ips_pkg::ips_rg_t          rg_c;
   logic [6:0]                idx_c;
   logic [6:0]                lvl_idx_c;
   logic                      win_nmi_c;
   logic                      win_any_c;
   logic [`IPS_ID_W-1:0]      win_id_c;
   ips_pkg::ips_lvl_t         win_lvl_c;
   logic [`IPS_NREQ-1:0]      clr_c;
   logic [`IPS_NREQ-1:0]      live_cand_c;
   logic [`IPS_NNMI-1:0]      live_ncand_c;

   assign setup_c = apb_i.psel && !apb_i.penable;
   assign acc_c   = apb_i.psel && apb_i.penable && s_r.pready;
   assign rg_c    = region(apb_i.paddr);
   assign idx_c   = apb_i.paddr[8:2];
   // Level words do not start on an index boundary; index from the offset
   assign lvl_idx_c = 7'((apb_i.paddr - `IPS_OFS_LVL) >> 2);
   assign live_cand_c  = request_in & s_r.en & ~s_r.hold;
   assign live_ncand_c = nonmaskable_in & ~s_r.nhold;

   // winner search on latched copies only
   always_comb begin
      win_nmi_c = 1'b0;
      win_any_c = 1'b0;
      win_id_c  = '0;
      win_lvl_c = '1;
      for (int i = 0; i < `IPS_NNMI; i++) begin
         if (s_r.ncand_l[i] && (!win_any_c || s_r.nlvl_l[i] < win_lvl_c)) begin
            win_any_c = 1'b1;
            win_nmi_c = 1'b1;
            win_id_c  = `IPS_ID_W'(i);
            win_lvl_c = s_r.nlvl_l[i];
         end
      end
      if (!win_nmi_c) begin
         for (int i = 0; i < `IPS_NREQ; i++) begin
            if (s_r.cand_l[i] && s_r.lvl_l[i] < s_r.mask_l &&
                (!win_any_c || s_r.lvl_l[i] < win_lvl_c)) begin
               win_any_c = 1'b1;
               win_id_c  = `IPS_ID_W'(i);
               win_lvl_c = s_r.lvl_l[i];
            end
         end
      end
   end

   // each clear byte needs its own strobe
   always_comb begin
      clr_c = '0;
      for (int w = 0; w < `IPS_HOLD_WORDS; w++) begin
         if (acc_c && apb_i.pwrite && rg_c == ips_pkg::RG_HCLR &&
             apb_i.pstrb[w/8] && apb_i.pwdata[w])
            clr_c[w*8 +: 8] = 8'hFF;
      end
   end

   always_comb begin
      s_nxt = s_r;
      // Registered answer: data prepared in setup, pready for one access
      s_nxt.pready  = setup_c;
      s_nxt.pslverr = setup_c && (rg_c == ips_pkg::RG_NONE);
      s_nxt.prdata  = '0;
      if (setup_c && !apb_i.pwrite) begin
         case (rg_c)
            ips_pkg::RG_MASK:    s_nxt.prdata[`IPS_LVL_W-1:0] = s_r.mask;
            ips_pkg::RG_STATUS:
               s_nxt.prdata[3:0] = {s_r.nmi_valid, s_r.vec_valid,
                                    s_r.st == ips_pkg::ST_EVAL,
                                    s_r.st != ips_pkg::ST_IDLE};
            ips_pkg::RG_NMI_VEC:
               s_nxt.prdata = {s_r.nmi_valid, 24'h0,
                               s_r.sel_id};
            ips_pkg::RG_NHOLD:   s_nxt.prdata[7:0] = s_r.nhold;
            ips_pkg::RG_EN:      s_nxt.prdata = s_r.en[idx_c[1:0]*32 +: 32];
            ips_pkg::RG_HOLD:    s_nxt.prdata[7:0] = s_r.hold[idx_c[3:0]*8 +: 8];
            ips_pkg::RG_LVL:
               s_nxt.prdata[`IPS_LVL_W-1:0] = s_r.lvl[lvl_idx_c];
            ips_pkg::RG_NLVL:
               s_nxt.prdata[`IPS_LVL_W-1:0] = s_r.nlvl[idx_c[2:0]];
            default:             s_nxt.prdata = '0;
         endcase
      end
      // Writes land only at the access edge; live copies always accept
      if (acc_c && apb_i.pwrite) begin
         case (rg_c)
            ips_pkg::RG_MASK:
               if (apb_i.pstrb[0])
                  s_nxt.mask = apb_i.pwdata[`IPS_LVL_W-1:0];
            ips_pkg::RG_NCLR:
               if (apb_i.pstrb[0])
                  s_nxt.nhold = s_r.nhold & ~apb_i.pwdata[7:0];
            ips_pkg::RG_EN:
               for (int b = 0; b < 4; b++) begin
                  if (apb_i.pstrb[b])
                     s_nxt.en[idx_c[1:0]*32 + b*8 +: 8] = apb_i.pwdata[b*8 +: 8];
               end
            ips_pkg::RG_LVL:
               if (apb_i.pstrb[0])
                  s_nxt.lvl[lvl_idx_c] = apb_i.pwdata[`IPS_LVL_W-1:0];
            ips_pkg::RG_NLVL:
               if (apb_i.pstrb[0])
                  s_nxt.nlvl[idx_c[2:0]] = apb_i.pwdata[`IPS_LVL_W-1:0];
            default: ;
         endcase
      end
      s_nxt.hold = s_r.hold & ~clr_c;
      case (s_r.st)
         ips_pkg::ST_IDLE: begin
            // mask copy frozen for this evaluation
            // hold status folded into frozen candidates
            // fresh copy taken every evaluation start
            if (|live_cand_c || |live_ncand_c) begin
               s_nxt.mask_l  = s_r.mask;
               s_nxt.lvl_l   = s_r.lvl;
               s_nxt.nlvl_l  = s_r.nlvl;
               s_nxt.cand_l  = live_cand_c;
               s_nxt.ncand_l = live_ncand_c;
               s_nxt.st      = ips_pkg::ST_EVAL;
            end
         end
         ips_pkg::ST_EVAL: begin
            s_nxt.sel_nmi   = win_nmi_c;
            s_nxt.sel_id    = win_id_c;
            s_nxt.sel_lvl   = win_lvl_c;
            s_nxt.vec_valid = win_any_c && !win_nmi_c;
            s_nxt.nmi_valid = win_any_c && win_nmi_c;
            s_nxt.st = win_any_c ? ips_pkg::ST_OFFER : ips_pkg::ST_IDLE;
         end
         ips_pkg::ST_OFFER: begin
            // hold set at fetch, wins over a same-cycle clear
            if (s_r.vec_valid && vec_ack) begin
               s_nxt.hold[s_r.sel_id] = 1'b1;
               s_nxt.vec_valid = 1'b0;
               s_nxt.st = ips_pkg::ST_IDLE;
            end
            // nonmaskable handover on vector address read
            if (s_r.nmi_valid && acc_c && !apb_i.pwrite &&
                rg_c == ips_pkg::RG_NMI_VEC) begin
               s_nxt.nhold[s_r.sel_id[`IPS_NID_W-1:0]] = 1'b1;
               s_nxt.nmi_valid = 1'b0;
               s_nxt.st = ips_pkg::ST_IDLE;
            end
         end
         default: s_nxt.st = ips_pkg::ST_IDLE;
      endcase
      // Busy kept in its own flop so the pin carries no decode glitch
      s_nxt.busy = (s_nxt.st != ips_pkg::ST_IDLE);
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_r        <= '0;
         s_r.st     <= ips_pkg::ST_IDLE;
         s_r.mask   <= `IPS_MASK_RST;
         s_r.mask_l <= `IPS_MASK_RST;
         s_r.lvl    <= {`IPS_NREQ{`IPS_LVL_RST}};
         s_r.lvl_l  <= {`IPS_NREQ{`IPS_LVL_RST}};
         s_r.nlvl   <= {`IPS_NNMI{`IPS_LVL_RST}};
         s_r.nlvl_l <= {`IPS_NNMI{`IPS_LVL_RST}};
      end else begin
         s_r <= s_nxt;
      end
   end

   assign prdata    = s_r.prdata;
   assign pready    = s_r.pready;
   assign pslverr   = s_r.pslverr;
   assign vec_valid = s_r.vec_valid;
   assign vec_id    = s_r.sel_id;
   assign vec_level = s_r.sel_lvl;
   assign nmi_valid = s_r.nmi_valid;
   assign nmi_id    = s_r.sel_id[`IPS_NID_W-1:0];
   assign busy      = s_r.busy;

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   sequence mask_write_s;
      acc_c && apb_i.pwrite && rg_c == ips_pkg::RG_MASK && apb_i.pstrb[0];
   endsequence
   sequence irq_fetch_s;
      vec_valid && vec_ack;
   endsequence
   sequence nmi_read_s;
      nmi_valid && acc_c && !apb_i.pwrite && rg_c == ips_pkg::RG_NMI_VEC;
   endsequence

   sel_below_mask_a: assert property (
      $rose(vec_valid) |-> vec_level < s_r.mask_l)
      else $error("offered level not below latched mask");
   nmi_over_irq_a: assert property (
      s_r.st == ips_pkg::ST_EVAL && |s_r.ncand_l |=> !vec_valid)
      else $error("ordinary request beat a nonmaskable one");
   hold_on_fetch_a: assert property (
      irq_fetch_s |=> s_r.hold[$past(vec_id)] && !vec_valid && !busy)
      else $error("hold not set on vector fetch");
   mask_frozen_a: assert property (
      s_r.st != ips_pkg::ST_IDLE |=> $stable(s_r.mask_l))
      else $error("latched mask moved during evaluation");
   mask_live_a: assert property (
      mask_write_s |=> s_r.mask == $past(apb_i.pwdata[3:0]))
      else $error("mask write lost");
   levels_frozen_a: assert property (
      s_r.st != ips_pkg::ST_IDLE |=> $stable(s_r.lvl_l) && $stable(s_r.nlvl_l))
      else $error("latched levels moved during evaluation");
   cand_frozen_a: assert property (
      s_r.st != ips_pkg::ST_IDLE |=> $stable(s_r.cand_l))
      else $error("latched candidates moved during evaluation");
   byte_clear_a: assert property (
      acc_c && apb_i.pwrite && rg_c == ips_pkg::RG_HCLR && !apb_i.pstrb[1]
      && !(vec_valid && vec_ack) |=> s_r.hold[127:64] == $past(s_r.hold[127:64]))
      else $error("unstrobed byte cleared hold bits");
   nmi_handover_a: assert property (
      nmi_read_s |=> s_r.nhold[$past(nmi_id)] && !nmi_valid && !busy)
      else $error("nonmaskable handover missed");
   offer_steady_a: assert property (
      vec_valid && !vec_ack |=> vec_valid && $stable(vec_id))
      else $error("offered vector changed before fetch");
   refresh_a: assert property (
      s_r.st == ips_pkg::ST_IDLE ##1 s_r.st == ips_pkg::ST_EVAL
      |-> s_r.mask_l == $past(s_r.mask))
      else $error("latched mask not refreshed at evaluation start");
   lvl_refresh_a: assert property (
      s_r.st == ips_pkg::ST_IDLE ##1 s_r.st == ips_pkg::ST_EVAL
      |-> s_r.lvl_l == $past(s_r.lvl) && s_r.nlvl_l == $past(s_r.nlvl))
      else $error("latched levels not refreshed at evaluation start");
   lvl_write_a: assert property (
      acc_c && apb_i.pwrite && rg_c == ips_pkg::RG_LVL && apb_i.pstrb[0]
      |=> s_r.lvl[$past(lvl_idx_c)] == $past(apb_i.pwdata[3:0]))
      else $error("level write landed on wrong request");
   byte_clear_lo_a: assert property (
      acc_c && apb_i.pwrite && rg_c == ips_pkg::RG_HCLR && !apb_i.pstrb[0]
      && !(vec_valid && vec_ack) |=> s_r.hold[63:0] == $past(s_r.hold[63:0]))
      else $error("unstrobed low byte cleared hold bits");
   idle_no_offer_a: assert property (
      !busy |=> !vec_valid && !nmi_valid)
      else $error("vector offered without an evaluation");
endmodule

// ---- verif/ips_core_model.sv ----
// Core side model: fetches the offered ordinary vector after a delay.
// Assumes the selector's vector port on the same pclk.
`timescale 1ns/1ps
module ips_core_model (
   // Clock and reset
   input  wire logic       pclk,
   input  wire logic       presetn,
   // Vector port
   input  wire logic       vec_valid,
   output logic            vec_ack,
   // Bench control: stall the fetch, or slow it
   input  wire logic       hold_off,
   input  wire logic [3:0] delay
);
   logic [3:0] wait_r;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         vec_ack <= 1'b0;
         wait_r  <= 4'h0;
      end else if (vec_ack) begin
         vec_ack <= 1'b0;
      end else if (vec_valid && !hold_off) begin
         if (wait_r >= delay) begin
            vec_ack <= 1'b1;
            wait_r  <= 4'h0;
         end else begin
            wait_r <= wait_r + 4'h1;
         end
      end
   end
endmodule

// ---- verif/tb_top.sv ----
// Self-checking bench of the interrupt priority selector.
// Assumes the core model answers the vector port; APB is driven here.
`timescale 1ns/1ps
`include "ips_map.svh"
module tb_top;
   typedef struct {string nm; logic [31:0] d, m; logic e;} ips_exp_t;
   logic                  pclk = 1'b0;
   logic                  presetn = 1'b0;
   ips_pkg::ips_apb_req_t apb_r = '0;
   logic [127:0]          req_r = '0;
   logic [7:0]            nmi_r = '0;
   logic [31:0]           prdata;
   logic                  pready, pslverr, vec_valid, vec_ack;
   logic                  nmi_valid, busy;
   logic [6:0]            vec_id;
   logic [3:0]            vec_level;
   logic [2:0]            nmi_id;
   logic                  hold_off = 1'b0;
   logic [3:0]            delay = 4'h0;
   int                    error_cnt = 0;
   int                    check_count = 0;
   ips_exp_t              rq[$];
   ips_exp_t              e_r;
   logic [10:0]           vq[$];
   logic [11:0]           v_r;

   always #2.5 pclk = ~pclk;

   ips_selector u_ips_selector (
      .pclk(pclk), .presetn(presetn), .apb_i(apb_r), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .request_in(req_r),
      .nonmaskable_in(nmi_r), .vec_valid(vec_valid), .vec_id(vec_id),
      .vec_level(vec_level), .vec_ack(vec_ack), .nmi_valid(nmi_valid),
      .nmi_id(nmi_id), .busy(busy));
   ips_core_model u_ips_core_model (
      .pclk(pclk), .presetn(presetn), .vec_valid(vec_valid),
      .vec_ack(vec_ack), .hold_off(hold_off), .delay(delay));

   task automatic check(string nm, logic [31:0] seen, logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         error_cnt++;
         $display("BAD %s exp %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic end_sim();
      $display("checks %0d errors %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic apb(bit w, logic [11:0] a, logic [31:0] d, logic [3:0] s);
      @(posedge pclk);
      apb_r <= '{1'b1, 1'b0, w, a, d, s};
      @(posedge pclk);
      apb_r.penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      apb_r.psel    <= 1'b0;
      apb_r.penable <= 1'b0;
   endtask
   task automatic wr(logic [11:0] a, logic [31:0] d, logic [3:0] s = 4'hF);
      apb(1'b1, a, d, s);
   endtask
   task automatic rd(string nm, logic [11:0] a, logic [31:0] d,
                     logic [31:0] m, logic e = 1'b0);
      rq.push_back('{nm, d, m, e});
      apb(1'b0, a, 32'h0, 4'h0);
   endtask
   function automatic logic [11:0] lvl_a(int k);
      return `IPS_OFS_LVL + 12'(4 * k);
   endfunction
   task automatic hchk(string nm, int k, bit set);
      logic [31:0] b = 32'h1 << (k % 8);
      rd(nm, `IPS_OFS_HOLD + 12'(4 * (k / 8)), set ? b : 32'h0, b);
   endtask
   task automatic wait_vq();
      for (int n = 0; n < 300 && vq.size() > 0; n++)
         @(posedge pclk);
      repeat (20) @(posedge pclk);
   endtask

   // Result watcher: APB read data and fetched vectors
   always @(posedge pclk) begin
      if (apb_r.psel && apb_r.penable && pready === 1'b1 && !apb_r.pwrite
          && rq.size() > 0) begin
         e_r = rq.pop_front();
         check(e_r.nm, prdata & e_r.m, e_r.d);
         check("slverr", {31'h0, pslverr}, {31'h0, e_r.e});
      end
      if (vec_valid === 1'b1 && vec_ack === 1'b1) begin
         v_r = (vq.size() > 0) ? {1'b1, vq.pop_front()} : 12'h0;
         check("vec", {20'h0, 1'b1, vec_id, vec_level}, {20'h0, v_r});
      end
   end

   initial begin
      #100000;
      error_cnt++;
      end_sim();
   end

   initial begin
      int k1, k2, k3, k4, j, m, l1, l2;
      void'($urandom(60));
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      rd("mask", `IPS_OFS_MASK, 32'hF, 32'hF);
      rd("unmap", 12'h080, 32'h0, 32'h0, 1'b1);
      for (int w = 0; w < 4; w++)
         wr(`IPS_OFS_EN + 12'(4 * w), 32'hFFFFFFFF);
      k1 = $urandom % 128;
      k2 = (k1 + 1 + $urandom % 40) % 128;
      k3 = (k2 + 1 + $urandom % 40) % 128;
      m  = 8 + $urandom % 8;
      l1 = $urandom % 4;
      l2 = 4 + $urandom % 4;
      wr(`IPS_OFS_MASK, 32'(m));
      wr(lvl_a(k1), 32'(l1));
      wr(lvl_a(k2), 32'(l2));
      wr(lvl_a(k3), 32'(m));
      vq.push_back({7'(k1), 4'(l1)});
      vq.push_back({7'(k2), 4'(l2)});
      req_r <= (128'h1 << k1) | (128'h1 << k2) | (128'h1 << k3);
      wait_vq();
      hchk("hold1", k1, 1'b1);
      hchk("hold2", k2, 1'b1);
      hchk("hold3", k3, 1'b0);
      req_r <= '0;
      wr(`IPS_OFS_HCLR, 32'hFFFF, 4'h1);
      hchk("hclr1", k1, k1 >= 64);
      hchk("hclr2", k2, k2 >= 64);
      wr(`IPS_OFS_HCLR, 32'hFFFF, 4'h2);
      hchk("hclr3", k1, 1'b0);
      hchk("hclr4", k2, 1'b0);
      // Offer stalled while mask and level change under it
      hold_off <= 1'b1;
      delay    <= 4'(1 + $urandom % 4);
      k4 = $urandom % 128;
      wr(`IPS_OFS_MASK, 32'hF);
      wr(lvl_a(k4), 32'h2);
      req_r <= 128'h1 << k4;
      for (int n = 0; n < 50 && vec_valid !== 1'b1; n++)
         @(posedge pclk);
      vq.push_back({7'(k4), 4'h2});
      wr(`IPS_OFS_MASK, 32'h1);
      wr(lvl_a(k4), 32'hE);
      hold_off <= 1'b0;
      wait_vq();
      wr(`IPS_OFS_HCLR, 32'hFFFF);
      repeat (20) @(posedge pclk);
      vq.push_back({7'(k4), 4'hE});
      wr(`IPS_OFS_MASK, 32'hF);
      wait_vq();
      req_r <= '0;
      wr(`IPS_OFS_HCLR, 32'hFFFF);
      // Nonmaskable handover by vector address read
      j = $urandom % 8;
      nmi_r <= 8'h1 << j;
      for (int n = 0; n < 50 && nmi_valid !== 1'b1; n++)
         @(posedge pclk);
      check("nmi_id", {29'h0, nmi_id}, 32'(j));
      check("busy", {31'h0, busy}, 32'h1);
      rd("nvec", `IPS_OFS_NMI_VEC, 32'h80000000 | 32'(j), 32'h8000007F);
      rd("nhold", `IPS_OFS_NHOLD, 32'h1 << j, 32'hFF);
      rd("stat", `IPS_OFS_STATUS, 32'h0, 32'h8);
      nmi_r <= '0;
      wr(`IPS_OFS_NCLR, 32'h1 << j);
      rd("nclr", `IPS_OFS_NHOLD, 32'h0, 32'hFF);
      repeat (5) @(posedge pclk);
      check("idle", {31'h0, busy}, 32'h0);
      check("left", 32'(rq.size() + vq.size()), 32'h0);
      end_sim();
   end
endmodule
